// >>> logic/port_consts.vh
// Constants of the parallel port block: offsets, fields, resets, timing.
// Included by the port top and nothing else needs to define them.
`ifndef PORT_CONSTS_VH
`define PORT_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL        8'h00
`define OFS_ADDRESS        8'h04
`define OFS_DATA           8'h08
`define OFS_STATUS         8'h0C

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define BIT_ENABLE         15
`define BIT_STOP_IN_IDLE   13
`define BIT_MUX_HI         12
`define BIT_MUX_LO         11
`define BIT_INPUT_BUF      10
`define BIT_WR_PIN_EN      9
`define BIT_RD_PIN_EN      8
`define BIT_CS_FUNC_HI     7
`define BIT_CS_FUNC_LO     6
`define BIT_LATCH_POL      5
`define CONTROL_MASK       32'h0000_BFEB
`define CONTROL_RESET      32'h0000_0000

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define MUX_SEPARATE       2'h0
`define MUX_LOW_PLUS_LINES 2'h1
`define MUX_FULL_16        2'h2
`define MUX_LOW_ONLY       2'h3
`define CS_FUNC_CHIP_SELECT 2'h2

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define BIT_BUSY           0
`define BIT_START_READ     1
`define BIT_HALTED         2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define STROBE_CYCLES      4

`endif

// >>> logic/sync_two_stage.v
// Two flip-flop synchroniser for a vector of pin inputs.
// Assumes each bit is sampled on its own; no bus coherence is implied.
`timescale 1ns/1ps

module sync_two_stage #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // Data
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // sync_two_stage

// >>> logic/parallel_port_block.v
// Parallel master port: AHB-Lite register slave plus off-chip access
// sequencer driving address, data, strobe and select pins.
// Assumes one AHB-Lite master, hclk at 50 MHz, pad logic resolves enables.
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "port_consts.vh"

module parallel_port_block #(
  parameter STROBE_CYCLES = `STROBE_CYCLES
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Device power state
  input  wire        idle_mode,
  // Data lines
  input  wire [7:0]  port_data_lines_in,
  output reg  [7:0]  port_data_lines_out,
  output reg         port_data_lines_oe,
  // Address lines
  output reg  [15:0] port_address_lines,
  output reg  [15:0] port_address_lines_oe,
  // Select, strobes, latches
  output reg         primary_select_pin,
  output reg         primary_select_pin_oe,
  output reg         write_strobe_pin,
  output reg         write_strobe_pin_oe,
  output reg         read_strobe_pin,
  output reg         read_strobe_pin_oe,
  output reg         addr_latch_low_strobe,
  output reg         addr_latch_high_strobe,
  output reg         latch_strobes_oe,
  // Pad configuration
  output reg         input_buffer_select
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [4:0] ST_IDLE   = 5'b00001;
  localparam [4:0] ST_ADDR_L = 5'b00010;
  localparam [4:0] ST_ADDR_H = 5'b00100;
  localparam [4:0] ST_STROBE = 5'b01000;
  localparam [4:0] ST_END    = 5'b10000;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Latch strobe level for a given polarity
  function latch_level;
    input pol;
    input active;
    begin
      latch_level = pol ? active : ~active;
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [31:0] control_reg;
  reg  [15:0] address_reg;
  reg  [7:0]  data_out_reg;
  reg  [7:0]  data_in_reg;
  reg         wr_pend_reg;
  reg         rd_pend_reg;
  reg  [7:0]  ofs_reg;
  reg  [4:0]  state_reg;
  reg  [4:0]  state_next;
  reg  [7:0]  cnt_reg;
  reg         dir_write_reg;
  reg  [15:0] acc_addr_reg;
  reg  [7:0]  acc_data_reg;
  wire [7:0]  data_in_sync;
  reg  [31:0] read_value;

  wire enable   = control_reg[`BIT_ENABLE];
  wire stop_idle = control_reg[`BIT_STOP_IN_IDLE];
  wire [1:0] mux = control_reg[`BIT_MUX_HI:`BIT_MUX_LO];
  wire [1:0] cs_func = control_reg[`BIT_CS_FUNC_HI:`BIT_CS_FUNC_LO];
  wire latch_pol = control_reg[`BIT_LATCH_POL];
  wire wr_en    = control_reg[`BIT_WR_PIN_EN];
  wire rd_en    = control_reg[`BIT_RD_PIN_EN];
  wire halted   = stop_idle & idle_mode;
  wire busy     = ~state_reg[0];
  wire addr_ph  = hsel & htrans[1] & hready;
  wire can_start = enable & ~halted & ~busy;
  wire start_wr = wr_pend_reg & (ofs_reg == `OFS_DATA) & can_start;
  wire start_rd = wr_pend_reg & (ofs_reg == `OFS_STATUS) &
                  hwdata[`BIT_START_READ] & can_start;
  wire last_cnt = (cnt_reg == 8'h00);

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  sync_two_stage #(
    .WIDTH (8)
  ) u_data_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (port_data_lines_in),
    .sync_out (data_in_sync)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  always @* begin
    read_value = 32'h0000_0000;
    case (ofs_reg)
      `OFS_CONTROL: read_value = control_reg & `CONTROL_MASK;
      `OFS_ADDRESS: read_value = {16'h0000, address_reg};
      `OFS_DATA:    read_value = {24'h00_0000, data_in_reg};
      `OFS_STATUS:  read_value = {29'h0000_0000, halted, 1'b0, busy};
      default:      read_value = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg  <= 1'b0;
      rd_pend_reg  <= 1'b0;
      ofs_reg      <= 8'h00;
      hrdata       <= 32'h0000_0000;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      control_reg  <= `CONTROL_RESET;
      address_reg  <= 16'h0000;
      data_out_reg <= 8'h00;
    end else begin
      hresp <= 1'b0;
      if (addr_ph) begin
        ofs_reg     <= {haddr[7:2], 2'b00};
        wr_pend_reg <= hwrite;
        rd_pend_reg <= ~hwrite;
        // One wait state so reads see the prior write
        hreadyout   <= hwrite;
      end else begin
        wr_pend_reg <= 1'b0;
        rd_pend_reg <= 1'b0;
        hreadyout   <= 1'b1;
      end
      if (rd_pend_reg) begin
        hrdata    <= read_value;
        hreadyout <= 1'b1;
      end
      if (wr_pend_reg) begin
        case (ofs_reg)
          `OFS_CONTROL: control_reg  <= hwdata & `CONTROL_MASK;
          `OFS_ADDRESS: address_reg  <= hwdata[15:0];
          `OFS_DATA:    data_out_reg <= hwdata[7:0];
          default:      ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_wr | start_rd) begin
          if (mux == `MUX_SEPARATE)
            state_next = ST_STROBE;
          else
            state_next = ST_ADDR_L;
        end
      end
      ST_ADDR_L: begin
        if (mux == `MUX_FULL_16)
          state_next = ST_ADDR_H;
        else
          state_next = ST_STROBE;
      end
      ST_ADDR_H: state_next = ST_STROBE;
      ST_STROBE: begin
        if (last_cnt)
          state_next = ST_END;
      end
      ST_END:  state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
    if (!enable)
      state_next = ST_IDLE;
    else if (halted)
      state_next = state_reg;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= 8'h00;
      dir_write_reg <= 1'b0;
      acc_addr_reg  <= 16'h0000;
      acc_data_reg  <= 8'h00;
      data_in_reg   <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (start_wr | start_rd) begin
        dir_write_reg <= start_wr;
        acc_addr_reg  <= address_reg;
        acc_data_reg  <= start_wr ? hwdata[7:0] : data_out_reg;
      end
      if (state_next == ST_STROBE && state_reg != ST_STROBE)
        cnt_reg <= STROBE_CYCLES[7:0] - 8'h01;
      else if (state_reg == ST_STROBE && !halted && !last_cnt)
        cnt_reg <= cnt_reg - 8'h01;
      if (state_reg == ST_STROBE && last_cnt && !halted && enable &&
          !dir_write_reg)
        data_in_reg <= data_in_sync;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, registered
  // ----------------------------------------------------------------
  wire in_acc   = busy & enable;
  wire strobing = (state_reg == ST_STROBE) & enable;
  wire lo_ph    = (state_reg == ST_ADDR_L) & enable;
  wire hi_ph    = (state_reg == ST_ADDR_H) & enable;
  wire [15:0] cur_addr = busy ? acc_addr_reg : address_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_data_lines_out    <= 8'h00;
      port_data_lines_oe     <= 1'b0;
      port_address_lines     <= 16'h0000;
      port_address_lines_oe  <= 16'h0000;
      primary_select_pin     <= 1'b0;
      primary_select_pin_oe  <= 1'b0;
      write_strobe_pin       <= 1'b0;
      write_strobe_pin_oe    <= 1'b0;
      read_strobe_pin        <= 1'b0;
      read_strobe_pin_oe     <= 1'b0;
      addr_latch_low_strobe  <= 1'b1;
      addr_latch_high_strobe <= 1'b1;
      latch_strobes_oe       <= 1'b0;
      input_buffer_select    <= 1'b0;
    end else begin
      input_buffer_select <= control_reg[`BIT_INPUT_BUF];
      // Data lines: address low byte, high byte in full-16 mode, none in separate mode, then write data
      if (lo_ph) begin
        port_data_lines_out <= acc_addr_reg[7:0];
        port_data_lines_oe  <= 1'b1;
      end else if (hi_ph) begin
        port_data_lines_out <= acc_addr_reg[15:8];
        port_data_lines_oe  <= 1'b1;
      end else if (strobing & dir_write_reg) begin
        port_data_lines_out <= acc_data_reg;
        port_data_lines_oe  <= 1'b1;
      end else begin
        port_data_lines_out <= 8'h00;
        port_data_lines_oe  <= 1'b0;
      end
      // Address lines by mux mode
      port_address_lines <= cur_addr;
      if (!enable)
        port_address_lines_oe <= 16'h0000;
      else if (mux == `MUX_SEPARATE)
        port_address_lines_oe <= 16'hFFFF;
      else if (mux == `MUX_LOW_PLUS_LINES)
        port_address_lines_oe <= 16'h4700;
      else
        port_address_lines_oe <= 16'h0000;
      // Latch strobes, or address 0/1 in separate mode
      latch_strobes_oe <= enable;
      if (mux == `MUX_SEPARATE) begin
        addr_latch_low_strobe  <= cur_addr[0];
        addr_latch_high_strobe <= cur_addr[1];
      end else begin
        addr_latch_low_strobe  <= latch_level(latch_pol, lo_ph);
        addr_latch_high_strobe <= latch_level(latch_pol, hi_ph);
      end
      // Select pin, write and read strobe pins
      primary_select_pin_oe <= enable;
      if (cs_func == `CS_FUNC_CHIP_SELECT && mux != `MUX_LOW_PLUS_LINES)
        primary_select_pin <= in_acc;
      else
        primary_select_pin <= cur_addr[14];
      write_strobe_pin_oe <= enable & wr_en;
      write_strobe_pin    <= enable & wr_en & strobing & dir_write_reg;
      read_strobe_pin_oe  <= enable & rd_en;
      read_strobe_pin     <= enable & rd_en & strobing & ~dir_write_reg;
    end
  end

endmodule // parallel_port_block

// >>> verif/parallel_port_block_properties.sv
// Checker of the parallel port pins against its control register.
// Assumes control writes at offset 0x00; bound to the port top.
`timescale 1ns/1ps

module parallel_port_block_properties #(
  parameter STROBE_CYCLES = 4
) (
  // Clock, reset, bus
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  // Pins
  input wire        idle_mode,
  input wire        port_data_lines_oe,
  input wire [15:0] port_address_lines,
  input wire [15:0] port_address_lines_oe,
  input wire        primary_select_pin,
  input wire        write_strobe_pin,
  input wire        write_strobe_pin_oe,
  input wire        read_strobe_pin,
  input wire        read_strobe_pin_oe,
  input wire        addr_latch_low_strobe,
  input wire        addr_latch_high_strobe
);
  logic [31:0] ctl;
  logic        wr_ph;
  logic [7:0]  ws_len;
  wire         en   = ctl[15];
  wire         halt = ctl[13] & idle_mode;
  wire  [1:0]  mux  = ctl[12:11];
  wire  [1:0]  cs_func   = ctl[7:6];
  wire         latch_pol = ctl[5];

  // Shadow of control register, strobe length
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl    <= 32'h0000_0000;
      wr_ph  <= 1'b0;
      ws_len <= 8'h00;
    end else begin
      ws_len <= write_strobe_pin ? ws_len + 8'h01 : 8'h00;
      if (hready) begin
        wr_ph <= hsel & htrans[1] & hwrite & (haddr[7:0] == 8'h00);
        if (wr_ph) ctl <= hwdata;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_off_no_strobe: assert property (
    !en && !$past(en) && !$past(en, 2) |-> !write_strobe_pin && !read_strobe_pin)
    else $error("strobe while port disabled");
  a_strobe_width: assert property (
    $fell(write_strobe_pin) && en |-> ws_len == STROBE_CYCLES)
    else $error("write strobe length wrong");
  a_halt_no_start: assert property (
    halt && $past(halt) && !write_strobe_pin |=> !write_strobe_pin)
    else $error("strobe while halted");
  a_upper_unused: assert property (
    mux == 2'h3 && $stable(mux) |-> port_address_lines_oe[15:8] == 8'h00)
    else $error("upper address driven in low-only mode");
  a_one_latch: assert property (
    mux[0] && $rose(write_strobe_pin) |->
      $past(addr_latch_low_strobe) == latch_pol
      && $past(addr_latch_low_strobe, 2) != latch_pol)
    else $error("single latch phase wrong");
  a_two_latch: assert property (
    mux == 2'h2 && $rose(write_strobe_pin) |->
      $past(addr_latch_high_strobe) == latch_pol
      && $past(addr_latch_low_strobe, 2) == latch_pol)
    else $error("two latch phases wrong");
  a_no_addr_phase: assert property (
    mux == 2'h0 && $rose(write_strobe_pin) |-> !$past(port_data_lines_oe))
    else $error("address phase on data in separate mode");
  a_wr_pin_off: assert property (
    !ctl[9] && !$past(ctl[9]) |-> !write_strobe_pin_oe)
    else $error("write strobe pin driven while off");
  a_rd_pin_off: assert property (
    !ctl[8] && !$past(ctl[8]) |-> !read_strobe_pin_oe)
    else $error("read strobe pin driven while off");
  a_cs_active: assert property (
    en && cs_func == 2'h2 && mux != 2'h1 && write_strobe_pin |->
      primary_select_pin)
    else $error("chip select low during strobe");
  a_cs_addr14: assert property (
    en && $past(en) && (cs_func != 2'h2 || mux == 2'h1) && $stable(ctl)
      && $stable(port_address_lines) |-> primary_select_pin
      == port_address_lines[14])
    else $error("select pin not address bit 14");
endmodule // parallel_port_block_properties

bind parallel_port_block parallel_port_block_properties #(
  .STROBE_CYCLES(STROBE_CYCLES)
) u_props (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .idle_mode, .port_data_lines_oe, .port_address_lines,
  .port_address_lines_oe, .primary_select_pin, .write_strobe_pin,
  .write_strobe_pin_oe, .read_strobe_pin, .read_strobe_pin_oe,
  .addr_latch_low_strobe, .addr_latch_high_strobe
);

// >>> verif/ext_memory_model.sv
// Byte-wide external memory answering the parallel port strobes.
// Assumes the bench tells it the mux mode and latch polarity in use.
`timescale 1ns/1ps

module ext_memory_model (
  // Clock and mode
  input  wire         hclk,
  input  wire  [1:0]  mux,
  input  wire         latch_pol,
  // Port pins
  input  wire  [7:0]  dout,
  input  wire         dout_oe,
  input  wire  [15:0] addr,
  input  wire  [15:0] addr_oe,
  input  wire         wr,
  input  wire         wr_oe,
  input  wire         rd,
  input  wire         rd_oe,
  input  wire         lat_lo,
  input  wire         lat_hi,
  // Observed access
  output wire  [7:0]  din,
  output logic [15:0] last_addr,
  output logic [7:0]  last_data
);
  logic [7:0]  mem [0:255];
  logic [15:0] lat = 16'h0000;
  logic [7:0]  pat = 8'h00;
  wire  [7:0]  hi  = mux == 2'h1 ? addr[15:8] & addr_oe[15:8] : 8'h00;
  wire  [15:0] ea  = mux == 2'h0 ? addr : mux == 2'h2 ? lat : {hi, lat[7:0]};

  // Released bus shows a moving pattern
  assign din = (rd && rd_oe) ? mem[ea[7:0]] : pat;

  always @(posedge hclk) begin
    pat <= pat + 8'h5B;
    if (mux != 2'h0 && dout_oe && lat_lo == latch_pol) lat[7:0] <= dout;
    if (mux == 2'h2 && dout_oe && lat_hi == latch_pol) lat[15:8] <= dout;
    if (wr && wr_oe) begin
      mem[ea[7:0]] <= dout;
      last_addr <= ea;
      last_data <= dout;
    end
  end
endmodule // ext_memory_model

// >>> verif/parallel_master_port_control_bench.sv
// Self-checking bench: register accesses start off-chip transfers that
// the memory model records. Assumes one 50 MHz clock, async low reset.
`timescale 1ns/1ps

module parallel_master_port_control_bench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        idle_mode = 1'b0;
  logic [1:0]  mux = 2'h0;
  logic        latch_pol = 1'b0;
  int          n_errors = 0;
  int          checks_done = 0;
  logic [15:0] ea [4] = '{16'h4A00, 16'h4201, 16'h4A02, 16'h0003};
  logic [15:0] ao [4] = '{16'hFFFF, 16'h4700, 16'h0000, 16'h0000};
  logic [31:0] cs_ctl [3] = '{32'h0000_8000, 32'h0000_8040, 32'h0000_8880};
  logic [31:0] cs_adr [3] = '{32'h0000_4123, 32'h0000_0123, 32'h0000_4123};
  wire  [31:0] hrdata;
  wire  [15:0] a_ln, a_oe, last_addr;
  wire  [7:0]  d_in, d_out, last_data;
  wire         hready, d_oe, cs, ws, ws_oe, rs, rs_oe, ll, lh;
  wire         hresp, ibs, cs_oe, lat_oe;

  parallel_port_block #(.STROBE_CYCLES(4)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .idle_mode(idle_mode), .port_data_lines_in(d_in),
    .port_data_lines_out(d_out), .port_data_lines_oe(d_oe),
    .port_address_lines(a_ln), .port_address_lines_oe(a_oe),
    .primary_select_pin(cs), .primary_select_pin_oe(cs_oe),
    .write_strobe_pin(ws), .write_strobe_pin_oe(ws_oe),
    .read_strobe_pin(rs), .read_strobe_pin_oe(rs_oe),
    .addr_latch_low_strobe(ll), .addr_latch_high_strobe(lh),
    .latch_strobes_oe(lat_oe), .input_buffer_select(ibs)
  );

  ext_memory_model u_mem (
    .hclk(hclk), .mux(mux), .latch_pol(latch_pol), .dout(d_out),
    .dout_oe(d_oe), .addr(a_ln), .addr_oe(a_oe), .wr(ws), .wr_oe(ws_oe),
    .rd(rs), .rd_oe(rs_oe), .lat_lo(ll), .lat_hi(lh), .din(d_in),
    .last_addr(last_addr), .last_data(last_data)
  );

  initial begin
    forever #10 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer, entered just after an edge
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0000_0000, x);
    check(x, e);
  endtask

  task automatic wait_idle;
    logic [31:0] s;
    s = 32'h0000_0001;
    while (s[0] !== 1'b0)
      bus(8'h0C, 1'b0, 32'h0000_0000, s);
  endtask

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    finish_test;
  end

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(8'h00, 32'h0000_0000);
    wr(8'h00, 32'hFFFF_FFFF);
    rd_chk(8'h00, 32'h0000_BFEB);
    check({hresp, ibs}, 2'h1);
    wr(8'h00, 32'h0000_0000);
    @(posedge hclk);
    $display("register test done");
    for (int m = 0; m < 4; m++) begin
      mux <= m[1:0];
      latch_pol <= m[0];
      wr(8'h00, 32'h0000_8380 | (m << 11) | ((m & 1) << 5));
      wr(8'h04, 32'h0000_4A00 | m);
      wr(8'h08, 32'h0000_00C0 + m);
      wait_idle;
      check(last_data, 32'h0000_00C0 + m);
      check(last_addr, ea[m]);
      check({ws_oe, rs_oe, cs_oe, lat_oe}, 4'hF);
      check(a_oe, ao[m]);
      wr(8'h0C, 32'h0000_0002);
      wait_idle;
      rd_chk(8'h08, 32'h0000_00C0 + m);
    end
    $display("mux mode test done");
    mux <= 2'h0;
    latch_pol <= 1'b0;
    wr(8'h00, 32'h0000_0000);
    @(posedge hclk);
    wr(8'h08, 32'h0000_0055);
    repeat (10) @(posedge hclk);
    check(last_data, 32'h0000_00C3);
    check({cs_oe, lat_oe, a_oe}, 18'h0_0000);
    wr(8'h00, 32'h0000_8000);
    wr(8'h08, 32'h0000_0066);
    wait_idle;
    check({ws_oe, rs_oe}, 2'h0);
    check(last_data, 32'h0000_00C3);
    $display("enable test done");
    wr(8'h00, 32'h0000_A300);
    idle_mode <= 1'b1;
    rd_chk(8'h0C, 32'h0000_0004);
    wr(8'h08, 32'h0000_0077);
    repeat (10) @(posedge hclk);
    check(last_data, 32'h0000_00C3);
    wr(8'h00, 32'h0000_8300);
    wr(8'h08, 32'h0000_0088);
    wait_idle;
    check(last_data, 32'h0000_0088);
    idle_mode <= 1'b0;
    $display("idle test done");
    for (int k = 0; k < 3; k++) begin
      wr(8'h00, cs_ctl[k]);
      wr(8'h04, cs_adr[k]);
      repeat (2) @(posedge hclk);
      check(cs, cs_adr[k][14]);
    end
    $display("select test done");
    wr(8'h00, 32'h0000_8300);
    wr(8'h08, 32'h0000_0099);
    wr(8'h00, 32'h0000_0000);
    @(posedge hclk);
    rd_chk(8'h0C, 32'h0000_0000);
    $display("abort test done");
    finish_test;
  end
endmodule // parallel_master_port_control_bench
